/* File: ntf_pkg.sv */
// shared constants, types and byte-order helpers for the packet fifo pair
// assumes a single 10 MHz ref_clk domain and apb register access
package ntf_pkg;

  // ==========================================================
  // register map
  localparam int unsigned    NTF_AW         = 12;
  localparam logic [11:0]    NTF_CFG_OFF    = 12'h000;
  localparam logic [11:0]    NTF_STAT_OFF   = 12'h004;
  localparam logic [5:0]     NTF_CFG_RST    = 6'h00;
  localparam int unsigned    NTF_RXTHR_POS  = 0;
  localparam int unsigned    NTF_TXTHR_POS  = 2;
  localparam int unsigned    NTF_BURST_POS  = 4;
  localparam int unsigned    NTF_W32_POS    = 5;
  localparam int unsigned    NTF_STRXC_POS  = 0;
  localparam int unsigned    NTF_STTXC_POS  = 8;
  localparam int unsigned    NTF_STRXQ_POS  = 16;
  localparam int unsigned    NTF_STTXQ_POS  = 17;
  localparam int unsigned    NTF_STBO_POS   = 18;
  localparam int unsigned    NTF_STRUN_POS  = 19;

  // ==========================================================
  // storage and thresholds
  localparam int unsigned    NTF_DEPTH      = 32;
  localparam int unsigned    NTF_CW         = 6;
  localparam logic [7:0]     NTF_FILL_BYTE  = 8'hFF;
  localparam logic [5:0]     NTF_THR0       = 6'd4;
  localparam logic [5:0]     NTF_THR1       = 6'd8;
  localparam logic [5:0]     NTF_THR2       = 6'd16;
  localparam logic [5:0]     NTF_THR3       = 6'd24;

  typedef enum logic [1:0] {RX_DATA, RX_PAD, RX_STAT, RX_FLUSH} ntf_rx_st_t;

  // ==========================================================
  // packet order <-> bus lanes; each mapping is its own inverse
  function automatic logic [31:0] ntf_order(input logic [31:0] d, input logic big, input logic w32);
    if (!big)
      return d;
    if (w32)
      return {d[7:0], d[15:8], d[23:16], d[31:24]};
    return {d[31:16], d[7:0], d[15:8]};
  endfunction : ntf_order

  function automatic logic [3:0] ntf_order_be(input logic [3:0] b, input logic big, input logic w32);
    if (!big)
      return b;
    if (w32)
      return {b[0], b[1], b[2], b[3]};
    return {b[3:2], b[0], b[1]};
  endfunction : ntf_order_be

  function automatic logic [5:0] ntf_thr(input logic [1:0] sel);
    case (sel)
      2'd0:    return NTF_THR0;
      2'd1:    return NTF_THR1;
      2'd2:    return NTF_THR2;
      default: return NTF_THR3;
    endcase
  endfunction : ntf_thr

endpackage : ntf_pkg

/* File: ntf_fifo_if.sv */
// byte-granular fifo port bundle between the control logic and its storage
// assumes both ends sit on ref_clk
`timescale 1ns/1ps
interface ntf_fifo_if;
  logic [2:0]  wr_n;
  logic [31:0] wr_data;
  logic [2:0]  rd_n;
  logic [31:0] rd_data;
  logic [5:0]  count;

  modport owner (output wr_n, output wr_data, output rd_n, input rd_data, input count);
  modport store (input wr_n, input wr_data, input rd_n, output rd_data, output count);
endinterface : ntf_fifo_if

/* File: ntf_fifo.sv */
// 4-byte wide circular byte store; up to four bytes in and out per cycle
// assumes the owner never writes past full nor reads past empty
`timescale 1ns/1ps
module ntf_fifo
  import ntf_pkg::*;
#(
  parameter int unsigned DEPTH = NTF_DEPTH
)
(
  // clock and reset
  input wire logic  ref_clk,
  input wire logic  rst_n,
  // storage side of the bundle
  ntf_fifo_if.store f
);

  localparam int unsigned AW = $clog2(DEPTH);

  if (DEPTH < 8 || DEPTH > 32 || (DEPTH & (DEPTH - 1)) != 0)
    $error("ntf_fifo: DEPTH must be a power of two from 8 to 32");

  logic [7:0]    mem [0:DEPTH-1];
  logic [AW-1:0] wp_ff;
  logic [AW-1:0] rp_ff;
  logic [5:0]    count_ff;
  logic [5:0]    nxt_count;

  // ==========================================================
  // byte lanes
  // one writer process: per-lane processes would all drive mem
  always_ff @(posedge ref_clk)
  begin
    for (int k = 0; k < 4; k++)
    begin
      if (k < int'(f.wr_n))
        mem[AW'(wp_ff + AW'(k))] <= f.wr_data[8*k +: 8];
    end
  end

  for (genvar k = 0; k < 4; k++)
  begin : g_lane
    assign f.rd_data[8*k +: 8] = mem[AW'(rp_ff + AW'(k))];
  end

  // ==========================================================
  // pointers and count
  assign nxt_count = count_ff + {3'b000, f.wr_n} - {3'b000, f.rd_n}; // RL22
  assign f.count   = count_ff;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wp_ff    <= '0;
      rp_ff    <= '0;
      count_ff <= '0;
    end
    else
    begin
      wp_ff    <= AW'(wp_ff + AW'(f.wr_n));
      rp_ff    <= AW'(rp_ff + AW'(f.rd_n));
      count_ff <= nxt_count;
    end
  end

  cnt_bound_a: assert property (@(posedge ref_clk) disable iff (!rst_n) count_ff <= 6'(DEPTH)) // RL22
    else $error("fifo count beyond depth");
  cnt_track_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL22
    ##1 count_ff == 6'($past(count_ff) + $past(f.wr_n) - $past(f.rd_n)))
    else $error("fifo count lost a write or read");

endmodule : ntf_fifo

/* File: ntf_top.sv */
// receive and transmit byte fifos with threshold dma requests and apb config
// assumes mac and dma engine logic run on ref_clk; only byte_order_pin is async
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// (RL1) rx store is 8 entries of 4 bytes
// (RL2) rx bytes steered by byte order
// (RL3) rx request only when count exceeds threshold; code also requests in flush at any nonzero count
// (RL4) rx read gives 16-bit half or 32-bit word
// (RL5) rerequest while count still above threshold
// (RL6) block mode moves threshold bytes per tenure; a flush tenure moves every whole word held
// (RL7) empty/fill mode drains rx store
// (RL8) pad last word with 0FFh bytes
// (RL9) status follows last byte, then flush
// (RL10) rx leaves only as whole aligned words
// (RL11) tx store 8x4 bytes, prefetched
// (RL12) tx write loads half or whole word
// (RL13) tx stream starts above threshold; code also starts once the last word is written, at any nonzero count
// (RL14) tx request at or below threshold
// (RL15) block moves threshold, fill fills store; a block is the word-rounded free room when room is not above threshold
// (RL16) tx reader order-aware, counts valid bytes
// (RL17) extraneous tx bytes dropped
// (RL18) tx fetch from any byte address
// (RL19) burst mode and thresholds are config
// (RL20) byte order pin selects endianness
// (RL21) data width from config bit
// (RL22) counts handle same-cycle write and read
module ntf_top
  import ntf_pkg::*;
(
  // clock and reset
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // apb slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [NTF_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  // strap
  input  wire logic              byte_order_pin,
  // receive mac side
  input  wire logic              rx_byte_valid,
  input  wire logic [7:0]        rx_byte,
  input  wire logic              rx_last,
  input  wire logic [31:0]       rx_status,
  output logic                   rx_byte_ready,
  // receive dma side
  input  wire logic              rx_dma_rd,
  output logic                   rx_dma_req,
  output logic      [31:0]       rx_dma_data,
  output logic                   rx_dma_dv,
  // transmit dma side
  input  wire logic              tx_dma_wr,
  input  wire logic [31:0]       tx_dma_data,
  input  wire logic [3:0]        tx_dma_be,
  input  wire logic              tx_dma_last,
  output logic                   tx_dma_req,
  // transmit mac side
  input  wire logic              tx_byte_ready,
  output logic                   tx_byte_valid,
  output logic      [7:0]        tx_byte
);
  import ntf_pkg::*;

  ntf_fifo_if rxf ();
  ntf_fifo_if txf ();

  ntf_fifo #(.DEPTH(NTF_DEPTH)) u_rx_store (.ref_clk(ref_clk), .rst_n(rst_n), .f(rxf)); // RL1
  ntf_fifo #(.DEPTH(NTF_DEPTH)) u_tx_store (.ref_clk(ref_clk), .rst_n(rst_n), .f(txf)); // RL11

  // ==========================================================
  // configuration and strap
  logic [5:0]  cfg_ff;
  logic        bo_meta_ff;
  logic        bo_ff;
  logic        burst;
  logic        w32;
  logic [5:0]  rx_thr;
  logic [5:0]  tx_thr;
  logic [5:0]  wb;
  logic [1:0]  lane_mask;

  assign burst     = cfg_ff[NTF_BURST_POS]; // RL19
  assign w32       = cfg_ff[NTF_W32_POS]; // RL21
  assign rx_thr    = ntf_thr(cfg_ff[NTF_RXTHR_POS +: 2]); // RL19
  assign tx_thr    = ntf_thr(cfg_ff[NTF_TXTHR_POS +: 2]);
  assign wb        = w32 ? 6'd4 : 6'd2;
  assign lane_mask = w32 ? 2'b11 : 2'b01;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bo_meta_ff <= 1'b0;
      bo_ff      <= 1'b0;
    end
    else
    begin
      bo_meta_ff <= byte_order_pin;
      bo_ff      <= bo_meta_ff; // RL20
    end
  end

  // ==========================================================
  // apb slave: one wait-free access, answer prepared in setup
  logic        pready_ff;
  logic        pslverr_ff;
  logic [31:0] prdata_ff;
  logic        apb_setup;
  logic        apb_wr;
  logic        rx_dma_req_ff;
  logic        tx_dma_req_ff;
  logic        tx_run_ff;

  assign apb_setup = psel && !penable;
  assign apb_wr    = psel && penable && pready_ff && pwrite;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
    end
    else
    begin
      pready_ff  <= apb_setup;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0000_0000;
      if (apb_setup)
      begin
        if (paddr == NTF_CFG_OFF)
          prdata_ff <= {26'h000_0000, cfg_ff};
        else if (paddr == NTF_STAT_OFF)
        begin
          prdata_ff[NTF_STRXC_POS +: 6] <= rxf.count;
          prdata_ff[NTF_STTXC_POS +: 6] <= txf.count;
          prdata_ff[NTF_STRXQ_POS]      <= rx_dma_req_ff;
          prdata_ff[NTF_STTXQ_POS]      <= tx_dma_req_ff;
          prdata_ff[NTF_STBO_POS]       <= bo_ff;
          prdata_ff[NTF_STRUN_POS]      <= tx_run_ff;
        end
        else
          pslverr_ff <= 1'b1;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
      cfg_ff <= NTF_CFG_RST;
    else if (apb_wr && paddr == NTF_CFG_OFF)
      cfg_ff <= pwdata[5:0]; // RL19
  end

  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // ==========================================================
  // receive write side: data, fill, status
  ntf_rx_st_t rx_st_ff;
  ntf_rx_st_t nxt_rx_st;
  logic [1:0]  rx_pos_ff;
  logic [31:0] rx_stat_ff;
  logic        rx_rdy_ff;
  logic        rx_take;
  logic        rx_fin;
  logic [5:0]  rx_cnt_nxt;
  logic [5:0]  rx_rem_ff;
  logic        rx_dv_ff;
  logic [31:0] rx_data_ff;
  logic        rx_pop;

  assign rx_take = rx_byte_valid && rx_rdy_ff && rx_st_ff == RX_DATA;
  // position after the byte written this cycle lands on a word edge
  assign rx_fin  = ((2'(rx_pos_ff + 2'd1)) & lane_mask) == 2'b00;

  always_comb
  begin
    nxt_rx_st   = rx_st_ff;
    rxf.wr_n    = 3'd0;
    rxf.wr_data = {24'h00_0000, rx_byte};
    case (rx_st_ff)
      RX_DATA:
      begin
        if (rx_take)
        begin
          rxf.wr_n = 3'd1; // RL2
          if (rx_last)
            nxt_rx_st = rx_fin ? RX_STAT : RX_PAD;
        end
      end
      RX_PAD:
      begin
        rxf.wr_data = {24'h00_0000, NTF_FILL_BYTE}; // RL8
        if (rxf.count < 6'(NTF_DEPTH))
        begin
          rxf.wr_n = 3'd1;
          if (rx_fin)
            nxt_rx_st = RX_STAT;
        end
      end
      RX_STAT:
      begin
        // status lands in lane order so it reads back as one bus word
        rxf.wr_data = ntf_order(rx_stat_ff, bo_ff, w32);
        if (rxf.count <= 6'(NTF_DEPTH) - wb)
        begin
          rxf.wr_n  = w32 ? 3'd4 : 3'd2; // RL9
          nxt_rx_st = RX_FLUSH;
        end
      end
      default:
      begin
        if (rxf.count == 6'd0 && !rx_dma_req_ff)
          nxt_rx_st = RX_DATA;
      end
    endcase
  end

  assign rx_pop     = rx_dma_req_ff && rx_dma_rd;
  assign rxf.rd_n   = rx_pop ? wb[2:0] : 3'd0; // RL10
  assign rx_cnt_nxt = rxf.count + {3'b000, rxf.wr_n} - {3'b000, rxf.rd_n}; // RL22

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_st_ff   <= RX_DATA;
      rx_pos_ff  <= 2'b00;
      rx_stat_ff <= 32'h0000_0000;
      rx_rdy_ff  <= 1'b0;
    end
    else
    begin
      rx_st_ff  <= nxt_rx_st;
      rx_rdy_ff <= nxt_rx_st == RX_DATA && rx_cnt_nxt < 6'(NTF_DEPTH);
      if (rx_take && rx_last)
        rx_stat_ff <= rx_status;
      if (nxt_rx_st == RX_FLUSH || nxt_rx_st == RX_STAT)
        rx_pos_ff <= 2'b00;
      else if (rxf.wr_n != 3'd0)
        rx_pos_ff <= 2'(rx_pos_ff + 2'd1);
    end
  end

  // ==========================================================
  // receive dma side: one tenure per request
  logic        rx_start;
  logic [31:0] rx_half;

  // in flush the store holds whole words only, so draining it stays aligned
  assign rx_start = !rx_dma_req_ff && (rxf.count > rx_thr || (rx_st_ff == RX_FLUSH && rxf.count != 6'd0)); // RL3 RL5
  // 16-bit pop: only the two low lanes belong to the word
  assign rx_half  = ntf_order(rxf.rd_data, bo_ff, 1'b0);

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_dma_req_ff <= 1'b0;
      rx_rem_ff     <= 6'd0;
    end
    else if (rx_start)
    begin
      rx_dma_req_ff <= 1'b1;
      if (rx_st_ff == RX_FLUSH || !burst)
        rx_rem_ff <= rxf.count & ~(wb - 6'd1); // RL7
      else
        rx_rem_ff <= rx_thr; // RL6
    end
    else if (rx_pop)
    begin
      rx_rem_ff <= rx_rem_ff - wb;
      if (rx_rem_ff <= wb)
        rx_dma_req_ff <= 1'b0;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rx_dv_ff   <= 1'b0;
      rx_data_ff <= 32'h0000_0000;
    end
    else
    begin
      rx_dv_ff <= rx_pop;
      if (rx_pop)
        rx_data_ff <= w32 ? ntf_order(rxf.rd_data, bo_ff, 1'b1) // RL4
                          : {16'h0000, rx_half[15:0]};
    end
  end

  assign rx_byte_ready = rx_rdy_ff;
  assign rx_dma_req    = rx_dma_req_ff;
  assign rx_dma_data   = rx_data_ff;
  assign rx_dma_dv     = rx_dv_ff;

  // ==========================================================
  // transmit dma side: lane steering and drop of unused lanes
  logic [31:0] tx_pk_data;
  logic [3:0]  tx_pk_be;
  logic [2:0]  tx_first;
  logic [2:0]  tx_n;
  logic        tx_take;
  logic [5:0]  tx_rem_ff;
  logic [5:0]  tx_room;
  logic        tx_done_ff;
  logic        tx_pop;
  logic        tx_vld_ff;
  logic [7:0]  tx_byte_ff;

  assign tx_pk_data = ntf_order(tx_dma_data, bo_ff, w32); // RL18
  assign tx_pk_be   = ntf_order_be(w32 ? tx_dma_be : {2'b00, tx_dma_be[1:0]}, bo_ff, w32); // RL12

  always_comb
  begin
    tx_first = 3'd0;
    tx_n     = 3'd0;
    for (int i = 3; i >= 0; i--)
    begin
      if (tx_pk_be[i])
        tx_first = 3'(i);
    end
    for (int i = 0; i < 4; i++)
      tx_n = tx_n + {2'b00, tx_pk_be[i]};
  end

  assign tx_take     = tx_dma_req_ff && tx_dma_wr;
  assign txf.wr_n    = tx_take ? tx_n : 3'd0; // RL17
  assign txf.wr_data = tx_pk_data >> {tx_first, 3'b000};
  assign tx_room     = 6'(NTF_DEPTH) - txf.count;

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_dma_req_ff <= 1'b0;
      tx_rem_ff     <= 6'd0;
    end
    else if (!tx_dma_req_ff)
    begin
      if (!tx_done_ff && txf.count <= tx_thr) // RL14
      begin
        tx_dma_req_ff <= 1'b1;
        // a block never outruns the free room, rounded to whole bus words
        if (burst && tx_thr < tx_room)
          tx_rem_ff <= tx_thr; // RL15
        else
          tx_rem_ff <= tx_room & ~(wb - 6'd1); // RL15
      end
    end
    else if (tx_take)
    begin
      tx_rem_ff <= tx_rem_ff - {3'b000, tx_n};
      if (tx_dma_last || tx_rem_ff < {3'b000, tx_n} + wb)
        tx_dma_req_ff <= 1'b0;
    end
  end

  // ==========================================================
  // transmit byte reader
  assign tx_pop   = tx_run_ff && txf.count != 6'd0 && (!tx_vld_ff || tx_byte_ready);
  assign txf.rd_n = tx_pop ? 3'd1 : 3'd0; // RL16

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_run_ff  <= 1'b0;
      tx_done_ff <= 1'b0;
    end
    else
    begin
      if (tx_take && tx_dma_last)
        tx_done_ff <= 1'b1;
      if (!tx_run_ff && (txf.count > tx_thr || (tx_done_ff && txf.count != 6'd0)))
        tx_run_ff <= 1'b1; // RL13
      else if (tx_run_ff && tx_done_ff && txf.count == 6'd0 && (!tx_vld_ff || tx_byte_ready))
      begin
        tx_run_ff  <= 1'b0;
        tx_done_ff <= 1'b0;
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_vld_ff  <= 1'b0;
      tx_byte_ff <= 8'h00;
    end
    else if (tx_pop)
    begin
      tx_vld_ff  <= 1'b1;
      tx_byte_ff <= txf.rd_data[7:0];
    end
    else if (tx_byte_ready)
      tx_vld_ff <= 1'b0;
  end

  assign tx_dma_req    = tx_dma_req_ff;
  assign tx_byte_valid = tx_vld_ff;
  assign tx_byte       = tx_byte_ff;

  // ==========================================================
  // checks
  rx_req_thr_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL3
    $rose(rx_dma_req_ff) && $past(rx_st_ff) != RX_FLUSH |-> $past(rxf.count) > $past(rx_thr))
    else $error("rx request below threshold");
  rx_block_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL6
    $rose(rx_dma_req_ff) && burst && $past(rx_st_ff) != RX_FLUSH |-> rx_rem_ff == rx_thr)
    else $error("rx block tenure not threshold sized");
  rx_fill_len_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL7
    $rose(rx_dma_req_ff) && !burst |-> rx_rem_ff == ($past(rxf.count) & ~(wb - 6'd1)))
    else $error("rx fill tenure does not drain");
  rx_stat_align_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL8
    rx_st_ff == RX_STAT |-> (rx_pos_ff & lane_mask) == 2'b00 && (rxf.count & (wb - 6'd1)) == 6'd0)
    else $error("status written off a word edge");
  rx_read_dv_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL10
    rx_pop |=> rx_dv_ff ##1 !rx_dv_ff || $past(rx_pop))
    else $error("rx read not answered next cycle");
  tx_req_thr_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL14
    $rose(tx_dma_req_ff) |-> $past(txf.count) <= $past(tx_thr) && !$past(tx_done_ff))
    else $error("tx request above threshold");
  tx_start_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL13
    $rose(tx_run_ff) |-> $past(txf.count) > $past(tx_thr) || $past(tx_done_ff))
    else $error("tx stream started early");
  tx_no_over_a: assert property (@(posedge ref_clk) disable iff (!rst_n) // RL15
    tx_take |-> {3'b000, tx_n} <= tx_room)
    else $error("tx write beyond free room");
  apb_answer_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
    apb_setup |=> pready_ff ##1 !pready_ff)
    else $error("apb answer not one cycle");

  rx_flush_c: cover property (@(posedge ref_clk) disable iff (!rst_n) rx_st_ff == RX_FLUSH ##1 rx_st_ff == RX_DATA);
  rx_pad_c:   cover property (@(posedge ref_clk) disable iff (!rst_n) rx_st_ff == RX_PAD && rxf.wr_n != 3'd0);
  tx_end_c:   cover property (@(posedge ref_clk) disable iff (!rst_n) $fell(tx_run_ff));
  apb_cfg_c:  cover property (@(posedge ref_clk) disable iff (!rst_n) apb_wr && paddr == NTF_CFG_OFF);

endmodule : ntf_top

/* File: ntf_far_model.sv */
// far-side model: dma engine pops and serializer accepts, both with stalls
// assumes ref_clk domain and registered rx_dma_req from the fifo block
`timescale 1ns/1ps
module ntf_far_model
(
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // bench control
  input  wire logic rx_en,
  // dma and serializer handshakes
  input  wire logic rx_dma_req,
  output logic      rx_dma_rd,
  output logic      tx_byte_ready
);
  logic [7:0] lfsr_ff;

  // ==========================================================
  // stall pattern
  always_ff @(posedge ref_clk or negedge rst_n)
    if (!rst_n)
      lfsr_ff <= 8'h5A;
    else
      lfsr_ff <= {lfsr_ff[6:0], lfsr_ff[7] ^ lfsr_ff[5] ^ lfsr_ff[4] ^ lfsr_ff[3]};

  // live req gate: no pop in the cycle after a tenure closes
  assign rx_dma_rd     = rx_en & rx_dma_req & (lfsr_ff[0] | lfsr_ff[2]);
  assign tx_byte_ready = lfsr_ff[1] | lfsr_ff[6];
endmodule : ntf_far_model

/* File: tb_top.sv */
// bench: apb config, rx bytes to dma words, dma words to tx bytes
// assumes ntf_pkg and ntf_far_model; expectations from a queue model here
`timescale 1ns/1ps
module tb_top;
  import ntf_pkg::*;
  logic              ref_clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [NTF_AW-1:0] paddr = '0;
  logic [31:0]       pwdata = '0, rx_status = '0, tx_dma_data = '0, prdata, rx_dma_data, rd, w;
  logic [31:0]       seed = 32'hFB53BB84;
  logic [7:0]        rx_byte = '0, tx_byte;
  logic [3:0]        tx_dma_be = '0;
  logic              byte_order_pin = 1'b0, rx_byte_valid = 1'b0, rx_last = 1'b0, tx_dma_wr = 1'b0;
  logic              tx_dma_last = 1'b0, rx_en = 1'b0, pready, pslverr, rx_byte_ready, rx_dma_rd;
  logic              rx_dma_req, rx_dma_dv, tx_dma_req, tx_byte_ready, tx_byte_valid, err;
  logic [31:0]       got_rx[$], exp_rx[$];
  logic [7:0]        got_tx[$], pkt[$];
  int                num_errors = 0, n_checks = 0;
  int                thr_tab[4] = '{NTF_THR0, NTF_THR1, NTF_THR2, NTF_THR3};

  ntf_top u_ntf_top (.ref_clk, .rst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .byte_order_pin, .rx_byte_valid, .rx_byte, .rx_last, .rx_status, .rx_byte_ready, .rx_dma_rd, .rx_dma_req,
    .rx_dma_data, .rx_dma_dv, .tx_dma_wr, .tx_dma_data, .tx_dma_be, .tx_dma_last, .tx_dma_req, .tx_byte_ready,
    .tx_byte_valid, .tx_byte);
  ntf_far_model u_ntf_far_model (.ref_clk, .rst_n, .rx_en, .rx_dma_req, .rx_dma_rd, .tx_byte_ready);

  // ==========================================================
  // helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd

  function automatic logic [7:0] rb();
    logic [31:0] r = rnd();
    return r[7:0];
  endfunction : rb

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask : complete_run

  task automatic apb(input logic wr, input logic [NTF_AW-1:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (!pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // valid stays up between bytes; caller lowers it
  task automatic put_byte(input logic [7:0] b, input logic l);
    rx_byte_valid <= 1'b1;
    rx_byte <= b;
    rx_last <= l;
    do @(posedge ref_clk); while (!rx_byte_ready);
  endtask : put_byte

  // ==========================================================
  // receive packet: threshold gate, lanes, pad, status
  task automatic run_rx(input logic w32, input logic big, input int thr);
    int len, wb, n;
    wb = w32 ? 4 : 2;
    len = thr + 2 + rnd() % 8;
    pkt.delete();
    got_rx.delete();
    exp_rx.delete();
    rx_status <= rnd();
    for (int i = 0; i < len; i++)
      pkt.push_back(rb());
    for (int i = 0; i < len; i++)
    begin
      if (i == thr || i == thr + 1)
      begin
        rx_byte_valid <= 1'b0;
        repeat (3) @(posedge ref_clk);
        check(rx_dma_req, i == thr + 1);
        rx_en <= (i == thr + 1);
      end
      put_byte(pkt[i], i == len - 1);
    end
    rx_byte_valid <= 1'b0;
    while (pkt.size() % wb)
      pkt.push_back(NTF_FILL_BYTE);
    for (int i = 0; i < pkt.size(); i += wb)
    begin
      w = '0;
      for (int j = 0; j < wb; j++)
        w[8 * (big ? wb - 1 - j : j) +: 8] = pkt[i + j];
      exp_rx.push_back(w);
    end
    exp_rx.push_back(w32 ? rx_status : {16'h0, rx_status[15:0]});
    n = 0;
    while ((got_rx.size() < exp_rx.size() || !rx_byte_ready) && n++ < 600)
      @(posedge ref_clk);
    check(got_rx.size(), exp_rx.size());
    foreach (exp_rx[k])
      check(got_rx[k], exp_rx[k]);
    check(rx_dma_req, 1'b0);
    rx_en <= 1'b0;
  endtask : run_rx

  // ==========================================================
  // transmit packet from a random offset below the bus width, extraneous lanes disabled
  task automatic run_tx(input logic w32, input logic big);
    int len, off, wb, nw, g, n;
    logic [3:0] be;
    wb = w32 ? 4 : 2;
    len = 1 + rnd() % 40;
    off = rnd() % wb;
    nw = (off + len + wb - 1) / wb;
    pkt.delete();
    got_tx.delete();
    for (int i = 0; i < len; i++)
      pkt.push_back(rb());
    for (int i = 0; i < nw; i++)
    begin
      w = rnd();
      be = 4'h0;
      for (int j = 0; j < wb; j++)
      begin
        g = i * wb + j - off;
        if (g >= 0 && g < len)
        begin
          w[8 * (big ? wb - 1 - j : j) +: 8] = pkt[g];
          be[big ? wb - 1 - j : j] = 1'b1;
        end
      end
      tx_dma_be <= be;
      tx_dma_wr <= 1'b1;
      tx_dma_data <= w;
      tx_dma_last <= (i == nw - 1);
      do @(posedge ref_clk); while (!tx_dma_req);
    end
    tx_dma_wr <= 1'b0;
    n = 0;
    while (got_tx.size() < len && n++ < 2000)
      @(posedge ref_clk);
    check(got_tx.size(), len);
    foreach (pkt[k])
      check(got_tx[k], pkt[k]);
  endtask : run_tx

  // ==========================================================
  // clock, watchdog, collectors, sequence
  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  initial
  begin
    #5000000;
    num_errors++;
    complete_run();
  end

  always @(posedge ref_clk)
  begin
    if (rx_dma_dv)
      got_rx.push_back(rx_dma_data);
    if (tx_byte_valid && tx_byte_ready)
      got_tx.push_back(tx_byte);
  end

  initial
  begin
    repeat (4) @(posedge ref_clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge ref_clk);
    check(rx_byte_ready, 1'b1);
    check(tx_dma_req, 1'b1);
    apb(1'b0, NTF_CFG_OFF, '0);
    check(rd, {26'h0, NTF_CFG_RST});
    apb(1'b0, 12'h008, '0);
    check(err, 1'b1);
    check(rd, 32'h0000_0000);
    for (int m = 0; m < 8; m++)
    begin
      w = rnd();
      byte_order_pin <= m[1];
      apb(1'b1, NTF_CFG_OFF, {26'h0, m[2], m[0], w[3:0]});
      apb(1'b0, NTF_CFG_OFF, '0);
      check(rd, {26'h0, m[2], m[0], w[3:0]});
      apb(1'b0, NTF_STAT_OFF, '0);
      // idle between packets: counts empty, rx tenure closed, tx tenure open
      check(rd, {12'h000, 1'b0, m[1], 1'b1, 1'b0, 16'h0000});
      run_rx(m[2], m[1], thr_tab[w[1:0]]);
      run_tx(m[2], m[1]);
    end
    complete_run();
  end
endmodule : tb_top
